// ### common/dvpc_pkg.sv
`default_nettype none
package dvpc_pkg;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam logic [31:0] CLK_MHZ    = 32'd100;
  localparam logic [31:0] T_10_US    = 32'd10;
  localparam logic [31:0] T_100_US   = 32'd100;
  localparam logic [31:0] T_1_MS     = 32'd1;
  localparam logic [31:0] T_2_MS     = 32'd2;
  localparam logic [31:0] T_4_MS     = 32'd4;
  localparam logic [31:0] T_10_MS    = 32'd10;
  localparam logic [31:0] T_50_MS    = 32'd50;
  localparam logic [31:0] T_100_MS   = 32'd100;
  localparam logic [31:0] T_200_MS   = 32'd200;
  localparam logic [31:0] T_400_MS   = 32'd400;
  localparam logic [31:0] T_800_MS   = 32'd800;
  localparam logic [31:0] T_2_S      = 32'd2;
  localparam logic [31:0] T_4_S      = 32'd4;
  localparam logic [31:0] CYC_10US   = T_10_US * CLK_MHZ;
  localparam logic [31:0] CYC_100US  = T_100_US * CLK_MHZ;
  localparam logic [31:0] CYC_1MS    = T_1_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_2MS    = T_2_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_4MS    = T_4_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_10MS   = T_10_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_50MS   = T_50_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_100MS  = T_100_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_200MS  = T_200_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_400MS  = T_400_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_800MS  = T_800_MS * 32'd1000 * CLK_MHZ;
  localparam logic [31:0] CYC_2S     = T_2_S * 32'd1000000 * CLK_MHZ;
  localparam logic [31:0] CYC_4S     = T_4_S * 32'd1000000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (indices, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 10;
  localparam logic [7:0]  IDX_LINK   = 8'h29;
  localparam logic [7:0]  IDX_POP    = 8'h2a;
  localparam logic [7:0]  IDX_LVOL   = 8'h2b;
  localparam logic [7:0]  IDX_RVOL   = 8'h2c;
  localparam logic [7:0]  IDX_CTRL   = 8'h30;
  localparam logic [7:0]  IDX_STAT   = 8'h31;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          WAIT_MSB   = 7;
  localparam int          WAIT_LSB   = 4;
  localparam int          STEP_MSB   = 3;
  localparam int          STEP_LSB   = 2;
  localparam int          VCM_BIT    = 1;
  localparam int          MUTE_BIT   = 7;
  localparam logic [7:0]  POP_RST    = 8'h00;
  localparam logic [7:0]  VOL_RST    = 8'h80;
  localparam logic [1:0]  LINK_RST   = 2'h0;
  localparam logic [1:0]  LINK_L_FR  = 2'h1;
  localparam logic [1:0]  LINK_R_FL  = 2'h2;
  localparam logic        CTRL_RST   = 1'b0;
  localparam logic [2:0]  RAMP_TOP   = 3'h7;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  typedef enum logic [3:0] {
    DVPC_OFF  = 4'h1,
    DVPC_WAIT = 4'h2,
    DVPC_RAMP = 4'h4,
    DVPC_ON   = 4'h8
  } dvpc_state_t;

endpackage
`default_nettype wire

// ### rtl/dvpc_atten.sv
`timescale 1ns/100ps
`default_nettype none
module dvpc_atten (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Setting
  input  wire logic [7:0]         vol,
  // Samples
  input  wire logic signed [15:0] smp_in,
  input  wire logic               smp_in_valid,
  output logic signed [15:0]      smp_out,
  output logic                    smp_out_valid
);

  // ----------------------------------------------------------------
  // Gain lookup
  // ----------------------------------------------------------------
  // Six dB is taken as one right shift; the 0.02 dB error per octave
  // was traded for a twelve-entry table instead of 128 entries.
  function automatic logic [15:0] frac_gain(input logic [3:0] k);
    case (k)
      4'h0:    frac_gain = 16'h8000;
      4'h1:    frac_gain = 16'h78d7;
      4'h2:    frac_gain = 16'h7215;
      4'h3:    frac_gain = 16'h6bb3;
      4'h4:    frac_gain = 16'h65ad;
      4'h5:    frac_gain = 16'h5ffd;
      4'h6:    frac_gain = 16'h5a9e;
      4'h7:    frac_gain = 16'h558c;
      4'h8:    frac_gain = 16'h50c3;
      4'h9:    frac_gain = 16'h4c3f;
      4'ha:    frac_gain = 16'h47fb;
      default: frac_gain = 16'h43f4;
    endcase
  endfunction

  logic [6:0]         code;
  logic [3:0]         shift;
  logic [3:0]         fine;
  logic signed [32:0] prod;

  assign code  = vol[6:0];
  assign shift = 4'(code / 7'd12);
  assign fine  = 4'(code % 7'd12);
  assign prod  = (33'(smp_in) * $signed({1'b0, frac_gain(fine)})) >>> 15;

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_out <= 16'sh0000;
    end else if (smp_in_valid) begin
      if (vol[dvpc_pkg::MUTE_BIT]) begin
        smp_out <= 16'sh0000;
      end else begin
        smp_out <= 16'(prod >>> shift);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_out_valid <= 1'b0;
    end else begin
      smp_out_valid <= smp_in_valid;
    end
  end

endmodule
`default_nettype wire

// ### rtl/dvpc_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module dvpc_top #(
  parameter logic [31:0] CYC_100US = dvpc_pkg::CYC_100US,
  parameter logic [31:0] CYC_1MS   = dvpc_pkg::CYC_1MS,
  parameter logic [31:0] CYC_2MS   = dvpc_pkg::CYC_2MS,
  parameter logic [31:0] CYC_4MS   = dvpc_pkg::CYC_4MS,
  parameter logic [31:0] CYC_10MS  = dvpc_pkg::CYC_10MS,
  parameter logic [31:0] CYC_50MS  = dvpc_pkg::CYC_50MS,
  parameter logic [31:0] CYC_100MS = dvpc_pkg::CYC_100MS,
  parameter logic [31:0] CYC_200MS = dvpc_pkg::CYC_200MS,
  parameter logic [31:0] CYC_400MS = dvpc_pkg::CYC_400MS,
  parameter logic [31:0] CYC_800MS = dvpc_pkg::CYC_800MS,
  parameter logic [31:0] CYC_2S    = dvpc_pkg::CYC_2S,
  parameter logic [31:0] CYC_4S    = dvpc_pkg::CYC_4S
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]             s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]             s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // DAC samples
  input  wire logic signed [15:0]     dac_l_in,
  input  wire logic signed [15:0]     dac_r_in,
  input  wire logic                   dac_in_valid,
  output logic signed [15:0]          dac_l_out,
  output logic signed [15:0]          dac_r_out,
  output logic                        dac_out_valid,
  // Output driver control
  output logic                        drv_powered,
  output logic [2:0]                  drv_ramp_level,
  output logic                        vcm_bandgap_sel
);

  // ----------------------------------------------------------------
  // Delay decode
  // ----------------------------------------------------------------
  // Reserved wait codes fall back to the longest wait.
  function automatic logic [31:0] wait_cycles(input logic [3:0] c);
    case (c)
      4'h0:    wait_cycles = 32'h0;
      4'h1:    wait_cycles = dvpc_pkg::CYC_10US;
      4'h2:    wait_cycles = CYC_100US;
      4'h3:    wait_cycles = CYC_1MS;
      4'h4:    wait_cycles = CYC_10MS;
      4'h5:    wait_cycles = CYC_50MS;
      4'h6:    wait_cycles = CYC_100MS;
      4'h7:    wait_cycles = CYC_200MS;
      4'h8:    wait_cycles = CYC_400MS;
      4'h9:    wait_cycles = CYC_800MS;
      4'ha:    wait_cycles = CYC_2S;
      default: wait_cycles = CYC_4S;
    endcase
  endfunction

  function automatic logic [31:0] step_cycles(input logic [1:0] c);
    case (c)
      2'h0:    step_cycles = 32'h0;
      2'h1:    step_cycles = CYC_1MS;
      2'h2:    step_cycles = CYC_2MS;
      default: step_cycles = CYC_4MS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0]              pop_r;
  logic [7:0]              lvol_r;
  logic [7:0]              rvol_r;
  logic [1:0]              link_r;
  logic                    ctrl_en_r;
  logic                    aw_got_r;
  logic                    w_got_r;
  logic [7:0]              aw_idx_r;
  logic [7:0]              wd_r;
  logic                    wstb_r;
  logic                    do_write;
  logic                    wr_hit;
  logic [7:0]              ar_idx;
  logic [31:0]             rd_val;
  logic                    rd_hit;
  dvpc_pkg::dvpc_state_t   st_r;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ar_idx        = s_axi_araddr[9:2];

  always_comb begin
    case (aw_idx_r)
      dvpc_pkg::IDX_LINK, dvpc_pkg::IDX_POP, dvpc_pkg::IDX_LVOL,
      dvpc_pkg::IDX_RVOL, dvpc_pkg::IDX_CTRL, dvpc_pkg::IDX_STAT: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      aw_idx_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr[9:2];
    end else if (do_write) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      wd_r    <= 8'h00;
      wstb_r  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      wd_r    <= s_axi_wdata[7:0];
      wstb_r  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dvpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dvpc_pkg::RESP_OKAY : dvpc_pkg::RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reserved POP bits are stored as written, LINK keeps bits 1:0 and CTRL bit 0 only; software keeps them legal.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pop_r     <= dvpc_pkg::POP_RST;
      lvol_r    <= dvpc_pkg::VOL_RST;
      rvol_r    <= dvpc_pkg::VOL_RST;
      link_r    <= dvpc_pkg::LINK_RST;
      ctrl_en_r <= dvpc_pkg::CTRL_RST;
    end else if (do_write && wstb_r) begin
      case (aw_idx_r)
        dvpc_pkg::IDX_POP:  pop_r     <= wd_r;
        dvpc_pkg::IDX_LVOL: lvol_r    <= wd_r;
        dvpc_pkg::IDX_RVOL: rvol_r    <= wd_r;
        dvpc_pkg::IDX_LINK: link_r    <= wd_r[1:0];
        dvpc_pkg::IDX_CTRL: ctrl_en_r <= wd_r[0];
        default:            ctrl_en_r <= ctrl_en_r;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      dvpc_pkg::IDX_LINK: rd_val = {30'h0, link_r};
      dvpc_pkg::IDX_POP:  rd_val = {24'h0, pop_r};
      dvpc_pkg::IDX_LVOL: rd_val = {24'h0, lvol_r};
      dvpc_pkg::IDX_RVOL: rd_val = {24'h0, rvol_r};
      dvpc_pkg::IDX_CTRL: rd_val = {31'h0, ctrl_en_r};
      dvpc_pkg::IDX_STAT: rd_val = {27'h0, drv_ramp_level,
                                    st_r == dvpc_pkg::DVPC_RAMP,
                                    drv_powered};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= dvpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? dvpc_pkg::RESP_OKAY : dvpc_pkg::RESP_SLV;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Driver power-up sequencer
  // ----------------------------------------------------------------
  logic [31:0] cnt_r;
  logic        cnt_done;

  assign cnt_done = cnt_r <= 32'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r           <= dvpc_pkg::DVPC_OFF;
      cnt_r          <= 32'h0;
      drv_ramp_level <= 3'h0;
    end else if (!ctrl_en_r) begin
      st_r           <= dvpc_pkg::DVPC_OFF;
      cnt_r          <= 32'h0;
      drv_ramp_level <= 3'h0;
    end else begin
      case (st_r)
        dvpc_pkg::DVPC_OFF: begin
          st_r  <= dvpc_pkg::DVPC_WAIT;
          cnt_r <= wait_cycles(pop_r[dvpc_pkg::WAIT_MSB:
                                     dvpc_pkg::WAIT_LSB]);
        end
        dvpc_pkg::DVPC_WAIT: begin
          if (cnt_done) begin
            st_r  <= dvpc_pkg::DVPC_RAMP;
            cnt_r <= step_cycles(pop_r[dvpc_pkg::STEP_MSB:
                                       dvpc_pkg::STEP_LSB]);
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        dvpc_pkg::DVPC_RAMP: begin
          if (cnt_done) begin
            drv_ramp_level <= drv_ramp_level + 3'h1;
            cnt_r <= step_cycles(pop_r[dvpc_pkg::STEP_MSB:
                                       dvpc_pkg::STEP_LSB]);
            if (drv_ramp_level == dvpc_pkg::RAMP_TOP - 3'h1) begin
              st_r <= dvpc_pkg::DVPC_ON;
            end
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        dvpc_pkg::DVPC_ON: begin
          st_r <= dvpc_pkg::DVPC_ON;
        end
        default: begin
          st_r <= dvpc_pkg::DVPC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_powered     <= 1'b0;
      vcm_bandgap_sel <= 1'b0;
    end else begin
      drv_powered     <= st_r == dvpc_pkg::DVPC_RAMP ||
                         st_r == dvpc_pkg::DVPC_ON;
      vcm_bandgap_sel <= pop_r[dvpc_pkg::VCM_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Digital volume
  // ----------------------------------------------------------------
  logic [7:0] l_eff;
  logic [7:0] r_eff;

  assign l_eff = (link_r == dvpc_pkg::LINK_L_FR) ? rvol_r : lvol_r;
  assign r_eff = (link_r == dvpc_pkg::LINK_R_FL) ? lvol_r : rvol_r;

  dvpc_atten u_left (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .vol           (l_eff),
    .smp_in        (dac_l_in),
    .smp_in_valid  (dac_in_valid),
    .smp_out       (dac_l_out),
    .smp_out_valid (dac_out_valid)
  );

  dvpc_atten u_right (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .vol           (r_eff),
    .smp_in        (dac_r_in),
    .smp_in_valid  (dac_in_valid),
    .smp_out       (dac_r_out),
    .smp_out_valid ()
  );

endmodule
`default_nettype wire

// ### verif/dvpc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dvpc_top_monitor (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Register bus
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // Samples and driver
  input wire logic               dac_in_valid,
  input wire logic               dac_out_valid,
  input wire logic signed [15:0] dac_l_out,
  input wire logic signed [15:0] dac_r_out,
  input wire logic               drv_powered,
  input wire logic [2:0]         drv_ramp_level,
  input wire logic               vcm_bandgap_sel
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_both |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rst;
    $rose(aresetn) |-> dac_l_out == 16'sh0 && dac_r_out == 16'sh0
      && !drv_powered && !vcm_bandgap_sel && s_axi_awready && !s_axi_bvalid;
  endproperty
  property p_smp;
    dac_in_valid |=> dac_out_valid;
  endproperty
  property p_smp_one;
    !dac_in_valid |=> !dac_out_valid;
  endproperty
  // A level may only drop to zero; any other change is one step up.
  property p_ramp;
    $changed(drv_ramp_level) && drv_ramp_level != 3'h0
      |-> drv_ramp_level == $past(drv_ramp_level) + 3'h1;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response missing");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_rst: assert property (p_rst)
    else $error("outputs wrong after reset");
  a_smp: assert property (p_smp)
    else $error("sample result missing");
  a_smp_one: assert property (p_smp_one)
    else $error("sample result unasked");
  a_ramp: assert property (p_ramp)
    else $error("ramp level skipped");
endmodule
bind dvpc_top dvpc_top_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .dac_in_valid,
  .dac_out_valid, .dac_l_out, .dac_r_out, .drv_powered,
  .drv_ramp_level, .vcm_bandgap_sel);
`default_nettype wire

// ### verif/tb_dac_volume_and_pop_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dac_volume_and_pop_control;
  // ------------------------------------------------------------
  // Signals and model
  // ------------------------------------------------------------
  // Short counts keep the 2 s and 4 s waits inside a short run.
  localparam logic [31:0] P = 32'h8;
  localparam logic [9:0] A_LINK = {dvpc_pkg::IDX_LINK, 2'h0};
  localparam logic [9:0] A_POP = {dvpc_pkg::IDX_POP, 2'h0};
  localparam logic [9:0] A_LVOL = {dvpc_pkg::IDX_LVOL, 2'h0};
  localparam logic [9:0] A_RVOL = {dvpc_pkg::IDX_RVOL, 2'h0};
  localparam logic [9:0] A_CTRL = {dvpc_pkg::IDX_CTRL, 2'h0};
  localparam logic [9:0] A_STAT = {dvpc_pkg::IDX_STAT, 2'h0};
  localparam logic [1:0] OK = dvpc_pkg::RESP_OKAY;
  localparam logic [1:0] SE = dvpc_pkg::RESP_SLV;
  localparam int LI = dvpc_pkg::IDX_LVOL;
  localparam int RI = dvpc_pkg::IDX_RVOL;
  logic aclk = 1'h0, aresetn = 1'h0, dac_in_valid = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1, stb = 4'h1;
  logic signed [15:0] dac_l_in = 16'sh0, dac_r_in = 16'sh0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dac_out_valid, drv_powered, vcm_bandgap_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic signed [15:0] dac_l_out, dac_r_out;
  logic [2:0] drv_ramp_level;
  int miscompares = 0, tests_run = 0, mr [256];
  dvpc_top #(.CYC_100US(P), .CYC_1MS(P), .CYC_2MS(P), .CYC_4MS(P),
    .CYC_10MS(P), .CYC_50MS(P), .CYC_100MS(P), .CYC_200MS(P),
    .CYC_400MS(P), .CYC_800MS(P), .CYC_2S(P), .CYC_4S(P)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dac_l_in, .dac_r_in, .dac_in_valid, .dac_l_out, .dac_r_out,
    .dac_out_valid, .drv_powered, .drv_ramp_level, .vcm_bandgap_sel);
  always #5 aclk = ~aclk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude;
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rst(input int c);
    foreach (mr[i]) mr[i] = 0;
    mr[LI] = 8'h80;
    mr[RI] = 8'h80;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (c) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  // Handshakes are judged at the falling edge, where nothing moves.
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit ta = 0, tw = 0, bd = 0, bv = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= stb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // A late ready makes the slave hold its response for a cycle.
    s_axi_bready <= 1'($urandom);
    while (!bd) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      bd = bv && s_axi_bready;
      if (bd) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (bv && !bd) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    if (er == OK && stb[0]) mr[a[9:2]] = d;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    bit ta = 0, got = 0, rv = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'($urandom);
    while (!got) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      got = rv && s_axi_rready;
      if (got) chk(s_axi_rdata, ed);
      if (got) chk(s_axi_rresp, er);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (rv && !got) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdm(input logic [9:0] a);
    rd(a, mr[a[9:2]], OK);
  endtask
  task automatic smp(input logic signed [15:0] l, r, el, er);
    @(posedge aclk);
    dac_l_in <= l;
    dac_r_in <= r;
    dac_in_valid <= 1'h1;
    @(posedge aclk);
    dac_in_valid <= 1'h0;
    @(negedge aclk);
    chk(dac_out_valid, 1'h1);
    chk(dac_l_out, el);
    chk(dac_r_out, er);
  endtask
  // Only whole 6 dB codes are predicted: the half-step table is open.
  function automatic logic signed [15:0] ex(int v, logic signed [15:0] x);
    if (v[7]) return 16'sh0;
    return x >>> ((v & 8'h7f) / 12);
  endfunction
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    int lv, rv, e, n, wc [3];
    logic signed [15:0] x, y, el, er;
    logic [7:0] d;
    wc = '{0, 1, 3};
    void'($urandom(9178));
    rst(8);
    rdm(A_POP);
    rdm(A_LVOL);
    rdm(A_RVOL);
    smp(16'sh1234, -16'sh100, 16'sh0, 16'sh0);
    for (int c = 0; c < 12; c++) begin
      d = {4'(c), 2'($urandom), 1'($urandom), 1'h0};
      wr(A_POP, d, OK);
      rdm(A_POP);
      chk(vcm_bandgap_sel, d[1]);
    end
    for (int k = 0; k < 4; k++) begin
      lv = 12 * ($urandom % 6) + (k == 0 ? 128 : 0);
      rv = 12 * ($urandom % 6) + (k == 2 ? 128 : 0);
      x = 16'($urandom & 32'h7fe0);
      y = 16'($urandom & 32'h7fe0);
      wr(A_LINK, 8'(k), OK);
      wr(A_LVOL, 8'(lv), OK);
      wr(A_RVOL, 8'(rv), OK);
      el = ex(mr[k == 1 ? RI : LI], x);
      er = ex(mr[k == 2 ? LI : RI], y);
      smp(x, y, el, er);
      rdm(A_LVOL);
      rdm(A_RVOL);
    end
    wr(A_LVOL, 8'h7f, OK);
    wr(A_RVOL, 8'h7f, OK);
    rdm(A_LVOL);
    rdm(A_RVOL);
    stb = 4'he;
    wr(A_LVOL, 8'h11, OK);
    stb = 4'h1;
    rdm(A_LVOL);
    wr(10'h3fc, 8'h55, SE);
    rd(10'h3fc, 32'h0, SE);
    wr(A_STAT, 8'h1f, OK);
    rd(A_STAT, 32'h0, OK);
    foreach (wc[i]) for (int s = 0; s < 4; s++) begin
      e = (wc[i] == 0 ? 0 : wc[i] == 1 ? 1000 : P) + 7 * (s == 0 ? 1 : P);
      wr(A_POP, {4'(wc[i]), 2'(s), 2'h0}, OK);
      wr(A_CTRL, 8'h1, OK);
      n = 0;
      while (drv_ramp_level !== 3'h7 && n < 1200) begin
        @(negedge aclk);
        n++;
      end
      chk(32'(n >= e - 4 && n <= e + 12), 32'h1);
      chk(drv_powered, 1'h1);
      rd(A_STAT, 32'h1d, OK);
      wr(A_CTRL, 8'h0, OK);
      // Enable drops with the response, the state one edge later, power one edge after that.
      repeat (2) @(negedge aclk);
      chk(drv_powered, 1'h0);
    end
    rst(2);
    rdm(A_LVOL);
    rdm(A_RVOL);
    rdm(A_POP);
    rdm(A_LINK);
    rdm(A_CTRL);
    conclude;
  end
  initial begin
    #400000;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire
